// *** logic/sdsr_params.svh ***
// Purpose: Constants for the scan data status responder.
// Assumes: Included by bare name; holds definitions only.
// Notes: Register offsets are byte addresses on the APB slave.
// Function
// - Header bytes 0-2 hold the count of status bytes after byte 3.
// - Descriptor is eight bytes: id, four reserved, 24-bit count MSB first.
// - Scan complete and all data moved: length zero, no descriptors.
// - Full buffers set the stall flag and hold generation until drained.
// - End of scan also sets the stall flag.
// - Stall flag is zero when neither full nor at end of scan; the code keeps it set while scan_hold waits for the drain.
// - Single-window header byte 3 carries stall in bit 0, other bits zero.
// - Descriptor id byte repeats the identifier the host gave the window.
// - Descriptor count is the bytes ready to send for that window.
// - A window with no data yet reports zero, which is no error.
// - All reserved bytes and bits are sent as zero.
// - Single-window variant returns at most one descriptor.
// - Vendor window flag limits status to the first window.
// - Vendor flag adds secondary area data into that one descriptor.
// - One descriptor per reported window, each for one window only.
// - Wait bit delays the answer until buffer fill reaches the limit; the code also answers once scan_end is set.
// - Sending stops at allocation length or end of status; zero sends nothing.
`ifndef SDSR_PARAMS_SVH
`define SDSR_PARAMS_SVH
`define SDSR_OFF_CTRL    8'h00
`define SDSR_OFF_WINEN   8'h04
`define SDSR_OFF_WINID   8'h08
`define SDSR_OFF_FILL    8'h0C
`define SDSR_OFF_STAT    8'h10
`define SDSR_OFF_MASK    8'h14
`define SDSR_OFF_INFO    8'h18
`define SDSR_CTRL_SINGLE 0
`define SDSR_CTRL_VENDOR 1
`define SDSR_EV_DONE     0
`define SDSR_EV_STALL    1
`define SDSR_EV_CMPL     2
`define SDSR_EV_W        3
`define SDSR_HDR_BYTES   3'h4
`define SDSR_POS_LEN_HI  3'h0
`define SDSR_POS_LEN_MD  3'h1
`define SDSR_POS_LEN_LO  3'h2
`define SDSR_DESC_SHIFT  3
`define SDSR_POS_STALL   3'h3
`define SDSR_POS_ID      3'h0
`define SDSR_POS_CNT_HI  3'h5
`define SDSR_POS_CNT_MD  3'h6
`define SDSR_POS_CNT_LO  3'h7
`endif

// *** logic/sdsr_pkg.sv ***
// Purpose: Types shared by the scan data status responder.
// Assumes: Constants live in sdsr_params.svh.
// Notes: Structs carry header and descriptor fields together.
package sdsr_pkg;
	typedef enum logic [2:0]
	{
		SDSR_IDLE = 3'b001,
		SDSR_WAIT = 3'b010,
		SDSR_SEND = 3'b100
	} sdsr_state_e;

	typedef struct packed
	{
		logic [23:0] len;
		logic        stall;
	} sdsr_hdr_s;

	typedef struct packed
	{
		logic [7:0]  id;
		logic [23:0] cnt;
	} sdsr_desc_s;
endpackage

// *** logic/sdsr_byte_mux.sv ***
// Purpose: Selects one response byte from the header or a descriptor.
// Assumes: Position is the byte number within the current part.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`include "sdsr_params.svh"
module sdsr_byte_mux
	import sdsr_pkg::*;
(
	input  wire logic       in_hdr,
	input  wire logic [2:0] pos,
	input  wire sdsr_hdr_s  hdr,
	input  wire sdsr_desc_s desc,
	output logic      [7:0] byte_o
);
	always_comb
	begin
		byte_o = 8'h00;
		if (in_hdr)
		begin
			unique case (pos)
				`SDSR_POS_LEN_HI: byte_o = hdr.len[23:16];
				`SDSR_POS_LEN_MD: byte_o = hdr.len[15:8];
				`SDSR_POS_LEN_LO: byte_o = hdr.len[7:0];
				`SDSR_POS_STALL: byte_o = {7'h00, hdr.stall};
				default:         byte_o = 8'h00;
			endcase
		end
		else
		begin
			unique case (pos)
				`SDSR_POS_ID:     byte_o = desc.id;
				`SDSR_POS_CNT_HI: byte_o = desc.cnt[23:16];
				`SDSR_POS_CNT_MD: byte_o = desc.cnt[15:8];
				`SDSR_POS_CNT_LO: byte_o = desc.cnt[7:0];
				default:          byte_o = 8'h00;
			endcase
		end
	end
endmodule // sdsr_byte_mux

// *** logic/sdsr_top.sv ***
// Purpose: Builds and streams the data status response of a scanner.
// Assumes: Scanner side inputs are synchronous to pclk; NWIN is at most 4.
// Notes: Counts are frozen when the answer starts so the bytes agree.
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "sdsr_params.svh"
module sdsr_top
	import sdsr_pkg::*;
#(
	parameter int NWIN = 4,
	parameter int ALW  = 16
)
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              req_valid,
	input  wire logic              req_wait,
	input  wire logic [ALW-1:0]    req_alloc,
	output logic                   req_busy,
	input  wire logic              buf_full,
	input  wire logic              scan_end,
	input  wire logic              xfer_done,
	input  wire logic [23:0]       fill_level,
	input  wire logic [NWIN*24-1:0] avail_cnt,
	input  wire logic [23:0]       sec_cnt,
	output logic                   scan_hold,
	output logic                   stall_flag,
	output logic                   tx_valid,
	output logic      [7:0]        tx_data,
	output logic                   tx_last,
	input  wire logic              tx_ready,
	output logic                   irq
);
	localparam int WIW = (NWIN > 1) ? $clog2(NWIN) : 1;

	sdsr_state_e             st;
	logic [1:0]              ctrl;
	logic [NWIN-1:0]         win_en;
	logic [NWIN*8-1:0]       win_id;
	logic [23:0]             fill_lim;
	logic [`SDSR_EV_W-1:0]   stat;
	logic [`SDSR_EV_W-1:0]   mask;
	logic [`SDSR_EV_W-1:0]   ev;
	logic [`SDSR_EV_W-1:0]   next_stat;
	logic [23:0]             snap [NWIN];
	logic [NWIN-1:0]         win_en_q;
	logic [WIW-1:0]          cur_win;
	logic [WIW-1:0]          first_win;
	logic [NWIN-1:0]         sel_mask;
	logic [ALW-1:0]          alloc_q;
	logic [ALW-1:0]          lim_q;
	logic [ALW-1:0]          bcnt;
	logic [ALW-1:0]          tx_idx;
	logic [ALW-1:0]          dofs;
	logic [ALW-1:0]          next_alloc;
	logic [ALW-1:0]          next_total;
	logic [23:0]             next_len;
	sdsr_hdr_s               hdr_q;
	sdsr_desc_s              desc_w;
	logic [7:0]              byte_w;
	logic                    in_hdr;
	logic                    not_ready;
	logic                    go;
	logic                    complete;
	logic                    tx_adv;
	logic                    done_ev;
	logic                    drained;
	logic                    next_hold;
	logic                    next_stall;
	logic                    wr_ok;
	logic                    rd_req;

	function automatic logic [WIW-1:0] next_en(input logic [NWIN-1:0] m, input int from);
		logic [WIW-1:0] r;
		r = '0;
		for (int i = NWIN - 1; i >= 0; i--)
		begin
			if (i >= from && m[i])
				r = WIW'(i);
		end
		return r;
	endfunction

	function automatic logic [ALW-1:0] ones(input logic [NWIN-1:0] m);
		logic [ALW-1:0] n;
		n = '0;
		for (int i = 0; i < NWIN; i++)
			n = n + ALW'(m[i]);
		return n;
	endfunction

	function automatic logic reg_hit(input logic [7:0] a);
		return a == `SDSR_OFF_CTRL || a == `SDSR_OFF_WINEN || a == `SDSR_OFF_WINID
			|| a == `SDSR_OFF_FILL || a == `SDSR_OFF_STAT || a == `SDSR_OFF_MASK
			|| a == `SDSR_OFF_INFO;
	endfunction

	assign wr_ok = psel && penable && pready && pwrite;
	assign rd_req = psel && penable && !pready;

	// Register file; the extra wait state lets prdata and pslverr come from flops.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			prdata   <= 32'h0000_0000;
			ctrl     <= 2'h0;
			win_en   <= '0;
			win_id   <= '0;
			fill_lim <= 24'h00_0000;
			mask     <= '0;
		end
		else if (ce)
		begin
			pready <= rd_req;
			if (rd_req)
			begin
				pslverr <= !reg_hit(paddr);
				prdata  <= 32'h0000_0000;
				unique case (paddr)
					`SDSR_OFF_CTRL:  prdata <= 32'(ctrl);
					`SDSR_OFF_WINEN: prdata <= 32'(win_en);
					`SDSR_OFF_WINID: prdata <= 32'(win_id);
					`SDSR_OFF_FILL:  prdata <= 32'(fill_lim);
					`SDSR_OFF_STAT:  prdata <= 32'(stat);
					`SDSR_OFF_MASK:  prdata <= 32'(mask);
					`SDSR_OFF_INFO:  prdata <= {req_busy, stall_flag, scan_hold, 5'h00, hdr_q.len};
					default:         prdata <= 32'h0000_0000;
				endcase
			end
			if (wr_ok)
			begin
				unique case (paddr)
					`SDSR_OFF_CTRL:  ctrl <= pwdata[1:0];
					`SDSR_OFF_WINEN: win_en <= pwdata[NWIN-1:0];
					`SDSR_OFF_WINID: win_id <= pwdata[NWIN*8-1:0];
					`SDSR_OFF_FILL:  fill_lim <= pwdata[23:0];
					`SDSR_OFF_MASK:  mask <= pwdata[`SDSR_EV_W-1:0];
					default:         ;
				endcase
			end
		end
	end

	// Buffer stall: the hold persists until the host has drained every window.
	assign drained = ~|avail_cnt;
	assign next_hold = buf_full || (scan_hold && !drained);
	assign next_stall = next_hold || scan_end;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scan_hold  <= 1'b0;
			stall_flag <= 1'b0;
		end
		else if (ce)
		begin
			scan_hold  <= next_hold;
			stall_flag <= next_stall;
		end
	end

	// Response planning, evaluated in the cycle the answer starts.
	assign not_ready = fill_level < fill_lim && !scan_end;
	assign go = (st == SDSR_IDLE && req_valid && !(req_wait && not_ready))
		|| (st == SDSR_WAIT && !not_ready);
	assign complete = scan_end && xfer_done;
	assign first_win = next_en(win_en, 0);

	always_comb
	begin
		sel_mask = win_en;
		if (ctrl[`SDSR_CTRL_SINGLE] || ctrl[`SDSR_CTRL_VENDOR])
			sel_mask = (|win_en) ? NWIN'(1) << first_win : '0;
		if (complete)
			sel_mask = '0;
	end

	assign next_alloc = (st == SDSR_IDLE) ? req_alloc : alloc_q;
	assign next_len = 24'(ones(sel_mask) << `SDSR_DESC_SHIFT);
	assign next_total = ALW'(next_len) + ALW'(`SDSR_HDR_BYTES);

	// Counts are frozen per window; a window not reached yet simply reads zero.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NWIN; i++)
				snap[i] <= 24'h00_0000;
		end
		else if (ce && go)
		begin
			for (int i = 0; i < NWIN; i++)
			begin
				snap[i] <= avail_cnt[i*24 +: 24];
				if (ctrl[`SDSR_CTRL_VENDOR] && first_win == WIW'(i))
					snap[i] <= avail_cnt[i*24 +: 24] + sec_cnt;
			end
		end
	end

	assign in_hdr = bcnt < ALW'(`SDSR_HDR_BYTES);
	assign dofs = bcnt - ALW'(`SDSR_HDR_BYTES);
	assign desc_w.id = win_id[cur_win*8 +: 8];
	assign desc_w.cnt = snap[cur_win];
	assign tx_adv = !tx_valid || tx_ready;
	assign done_ev = st == SDSR_SEND && tx_adv && bcnt >= lim_q;

	sdsr_byte_mux u_mux
	(
		.in_hdr (in_hdr),
		.pos    (in_hdr ? bcnt[2:0] : dofs[2:0]),
		.hdr    (hdr_q),
		.desc   (desc_w),
		.byte_o (byte_w)
	);

	// Request and byte stream sequencing.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st       <= SDSR_IDLE;
			req_busy <= 1'b0;
			alloc_q  <= '0;
			lim_q    <= '0;
			bcnt     <= '0;
			tx_idx   <= '0;
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
			tx_last  <= 1'b0;
			hdr_q    <= '0;
			win_en_q <= '0;
			cur_win  <= '0;
		end
		else if (ce)
		begin
			unique case (st)
				SDSR_IDLE:
				begin
					if (req_valid)
					begin
						alloc_q  <= req_alloc;
						req_busy <= 1'b1;
						st       <= go ? SDSR_SEND : SDSR_WAIT;
					end
				end
				SDSR_WAIT:
				begin
					if (go)
						st <= SDSR_SEND;
				end
				SDSR_SEND:
				begin
					if (tx_adv)
					begin
						if (bcnt < lim_q)
						begin
							tx_valid <= 1'b1;
							tx_data  <= byte_w;
							tx_idx   <= bcnt;
							tx_last  <= bcnt + ALW'(1) == lim_q;
							bcnt     <= bcnt + ALW'(1);
							if (!in_hdr && dofs[2:0] == `SDSR_POS_CNT_LO)
								cur_win <= next_en(win_en_q, int'(cur_win) + 1);
						end
						else
						begin
							tx_valid <= 1'b0;
							tx_last  <= 1'b0;
							req_busy <= 1'b0;
							st       <= SDSR_IDLE;
						end
					end
				end
			endcase
			if (go)
			begin
				bcnt      <= '0;
				hdr_q.len <= next_len;
				hdr_q.stall <= stall_flag;
				lim_q     <= (next_total < next_alloc) ? next_total : next_alloc;
				win_en_q  <= sel_mask;
				cur_win   <= next_en(sel_mask, 0);
			end
		end
	end

	// Events are sticky; a write of one clears, but a same-cycle event wins.
	always_comb
	begin
		ev = '0;
		ev[`SDSR_EV_DONE]  = done_ev;
		ev[`SDSR_EV_STALL] = next_stall && !stall_flag;
		ev[`SDSR_EV_CMPL]  = go && complete;
		next_stat = stat;
		if (wr_ok && paddr == `SDSR_OFF_STAT)
			next_stat = next_stat & ~pwdata[`SDSR_EV_W-1:0];
		next_stat = next_stat | ev;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stat <= '0;
			irq  <= 1'b0;
		end
		else if (ce)
		begin
			stat <= next_stat;
			irq  <= |(next_stat & mask);
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_byte_taken;
		ce && tx_valid && tx_ready && !tx_last;
	endsequence

	sequence s_next_byte;
		tx_valid && tx_idx == $past(tx_idx) + ALW'(1);
	endsequence

	AST_LEN_LSB: assert property (tx_valid && tx_idx == ALW'(2) |-> tx_data == hdr_q.len[7:0])
		else $error("Header length byte differs from length field.");
	AST_DESC_RSVD: assert property (tx_valid && tx_idx >= ALW'(`SDSR_HDR_BYTES)
		&& (tx_idx - ALW'(`SDSR_HDR_BYTES)) % 8 inside {[1:4]} |-> tx_data == 8'h00)
		else $error("Reserved descriptor byte is not zero.");
	AST_CMPL_ZERO: assert property (ce && go && complete |=> hdr_q.len == 24'h00_0000)
		else $error("Completed scan reports nonzero length.");
	AST_HOLD_SET: assert property (ce && buf_full |=> scan_hold && stall_flag)
		else $error("Full buffer did not set the stall flag.");
	AST_END_STALL: assert property (ce && scan_end |=> stall_flag)
		else $error("End of scan did not set the stall flag.");
	AST_STALL_CLR: assert property (ce && !buf_full && !scan_end && drained |=> !stall_flag)
		else $error("Stall flag set without cause.");
	AST_STALL_BYTE: assert property (tx_valid && tx_idx == ALW'(`SDSR_POS_STALL)
		|-> tx_data == {7'h00, hdr_q.stall})
		else $error("Header byte three layout wrong.");
	AST_ONE_DESC: assert property (ce && go && (ctrl[`SDSR_CTRL_SINGLE] || ctrl[`SDSR_CTRL_VENDOR])
		|=> hdr_q.len <= 24'h00_0008)
		else $error("Single window answer has several descriptors.");
	AST_WAIT_HOLD: assert property (ce && st == SDSR_WAIT && not_ready |=> st == SDSR_WAIT)
		else $error("Answer started before fill limit.");
	AST_ALLOC_CAP: assert property (tx_valid |-> tx_idx < lim_q && lim_q <= alloc_q)
		else $error("Byte sent beyond allocation length.");
	AST_ASCENDING: assert property (s_byte_taken |=> s_next_byte)
		else $error("Response bytes out of order.");
endmodule // sdsr_top

// *** tb/sdsr_host.sv ***
// Purpose: Host model that issues status requests and sinks the response bytes.
// Assumes: Requests are made only while the responder is idle.
// Notes: tx_ready drops at random so that held bytes are exercised.
`timescale 1ns/10ps
module sdsr_host
(
	input  wire logic        pclk,
	input  wire logic        ce,
	input  wire logic        req_busy,
	input  wire logic        tx_valid,
	input  wire logic [7:0]  tx_data,
	input  wire logic        tx_last,
	output logic             req_valid,
	output logic             req_wait,
	output logic [15:0]      req_alloc,
	output logic             tx_ready
);
	logic [7:0] got[$];
	int         last_at;
	logic       hung;

	initial
	begin
		req_valid = 1'b0;
		req_wait = 1'b0;
		req_alloc = 16'h0000;
		tx_ready = 1'b0;
		hung = 1'b0;
	end

	// A random sink stall shows whether a byte is held until it is taken.
	always @(posedge pclk)
	begin
		if (ce && tx_valid && tx_ready)
		begin
			got.push_back(tx_data);
			if (tx_last)
				last_at = got.size();
		end
		tx_ready <= ($urandom_range(0, 3) != 0);
	end

	task automatic issue(input logic w, input logic [15:0] alloc);
		int k;
		got.delete();
		last_at = 0;
		@(posedge pclk);
		req_valid <= 1'b1;
		req_wait <= w;
		req_alloc <= alloc;
		@(posedge pclk);
		req_valid <= 1'b0;
		@(posedge pclk);
		k = 0;
		while (req_busy && k < 2000)
		begin
			@(posedge pclk);
			k++;
		end
		if (k >= 2000)
			hung = 1'b1;
	endtask
endmodule // sdsr_host

// *** tb/scan_data_status_responder_test.sv ***
// Purpose: Self-checking bench of the scan data status responder.
// Assumes: Clock enable is high except for one frozen stretch mid-response.
// Notes: Expected bytes are rebuilt from the mirrored register values.
`timescale 1ns/10ps
`include "sdsr_params.svh"
module scan_data_status_responder_test;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, winid;
	logic        req_valid, req_wait, req_busy, buf_full, scan_end, xfer_done;
	logic [15:0] req_alloc;
	logic [23:0] fill_level, sec_cnt;
	logic [95:0] avail_cnt;
	logic        scan_hold, stall_flag, tx_valid, tx_last, tx_ready, irq, hold_e, ce;
	logic [7:0]  tx_data;
	logic [1:0]  ctrl;
	logic [3:0]  winen;
	logic [7:0]  exp_q[$];
	int          errors, n_tests;

	sdsr_top #(.NWIN(4), .ALW(16)) u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .req_valid(req_valid), .req_wait(req_wait), .req_alloc(req_alloc), .req_busy(req_busy),
		.buf_full(buf_full), .scan_end(scan_end), .xfer_done(xfer_done), .fill_level(fill_level),
		.avail_cnt(avail_cnt), .sec_cnt(sec_cnt), .scan_hold(scan_hold), .stall_flag(stall_flag),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .irq(irq));
	sdsr_host u_host (.pclk(pclk), .ce(ce), .req_busy(req_busy), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_last(tx_last), .req_valid(req_valid), .req_wait(req_wait), .req_alloc(req_alloc), .tx_ready(tx_ready));

	task automatic final_report();
		if (errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		k = 0;
		while (pready !== 1'b1 && k < 50)
		begin
			@(posedge pclk);
			k++;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50)
		begin
			errors++;
			final_report();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	// Hold stays set after the buffers free up until every window is drained.
	task automatic set_scan(input logic bf, input logic se, input logic xd, input logic [95:0] av);
		@(posedge pclk);
		buf_full <= bf;
		scan_end <= se;
		xfer_done <= xd;
		avail_cnt <= av;
		if (bf)
			hold_e = 1'b1;
		else if (av == 96'h0)
			hold_e = 1'b0;
		repeat (3) @(posedge pclk);
		check(scan_hold, hold_e);
		check(stall_flag, bf | se | hold_e);
	endtask

	task automatic run(input logic w, input logic [15:0] alloc);
		logic [23:0] len, c;
		int          n;
		n = 0;
		exp_q.delete();
		for (int i = 0; i < 4; i++)
			if (winen[i] && !(scan_end && xfer_done) && !(ctrl != 2'h0 && n > 0))
			begin
				c = avail_cnt[i*24+:24] + ((ctrl[1] && n == 0) ? sec_cnt : 24'h000000);
				exp_q.push_back(winid[i*8+:8]);
				repeat (4) exp_q.push_back(8'h00);
				exp_q.push_back(c[23:16]);
				exp_q.push_back(c[15:8]);
				exp_q.push_back(c[7:0]);
				n++;
			end
		len = 24'(n * 8);
		exp_q.push_front({7'h00, buf_full | scan_end | hold_e});
		exp_q.push_front(len[7:0]);
		exp_q.push_front(len[15:8]);
		exp_q.push_front(len[23:16]);
		while (exp_q.size() > alloc)
			void'(exp_q.pop_back());
		u_host.issue(w, alloc);
		check(u_host.hung, 1'b0);
		if (u_host.hung)
			final_report();
		check(u_host.got.size(), exp_q.size());
		foreach (exp_q[i]) check(u_host.got[i], exp_q[i]);
		check(u_host.last_at, exp_q.size());
	endtask

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial
	begin
		logic [31:0] q;
		logic        e;
		logic [95:0] av;
		{presetn, psel, penable, pwrite, paddr, pwdata, buf_full, scan_end, xfer_done} = '0;
		ce = 1'b1;
		{fill_level, sec_cnt, avail_cnt, errors, n_tests, hold_e, ctrl, winen} = '0;
		void'($urandom(32'hAA74CF61));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		winid = $urandom();
		wr(`SDSR_OFF_WINID, winid);
		apb(1'b0, `SDSR_OFF_WINID, 32'h0, q, e);
		check(q, winid);
		check(e, 1'b0);
		apb(1'b0, 8'h40, 32'h0, q, e);
		check(q, 32'h0000_0000);
		check(e, 1'b1);
		wr(`SDSR_OFF_FILL, 32'h80);
		winen = 4'hF;
		wr(`SDSR_OFF_WINEN, 32'hF);
		av = {24'h000000, 24'h123456, 24'hABCDEF, 24'h000001};
		set_scan(1'b0, 1'b0, 1'b0, av);
		run(1'b0, 16'h40);
		check(irq, 1'b0);
		wr(`SDSR_OFF_MASK, 32'h1);
		repeat (2) @(posedge pclk);
		check(irq, 1'b1);
		wr(`SDSR_OFF_STAT, 32'h7);
		repeat (2) @(posedge pclk);
		check(irq, 1'b0);
		fork
			run(1'b1, 16'h40);
			begin
				repeat (20) @(posedge pclk);
				check(tx_valid, 1'b0);
				fill_level <= 24'h90;
			end
		join
		// Freezing mid-response must neither drop nor repeat a byte.
		fork
			run(1'b0, 16'h40);
			begin
				repeat (8) @(posedge pclk);
				ce <= 1'b0;
				repeat (6) @(posedge pclk);
				check(req_busy, 1'b1);
				ce <= 1'b1;
			end
		join
		set_scan(1'b1, 1'b0, 1'b0, av);
		set_scan(1'b0, 1'b0, 1'b0, av);
		run(1'b0, 16'h0);
		set_scan(1'b0, 1'b1, 1'b1, 96'h0);
		run(1'b0, 16'h40);
		apb(1'b0, `SDSR_OFF_STAT, 32'h0, q, e);
		check(q, 32'h0000_0007);
		apb(1'b0, `SDSR_OFF_INFO, 32'h0, q, e);
		check(q, 32'h4000_0000);
		check(irq, 1'b1);
		repeat (12)
		begin
			ctrl = 2'($urandom_range(0, 3));
			winen = 4'($urandom());
			wr(`SDSR_OFF_CTRL, {30'h0, ctrl});
			wr(`SDSR_OFF_WINEN, {28'h0, winen});
			sec_cnt <= 24'($urandom());
			for (int i = 0; i < 4; i++)
				av[i*24+:24] = ($urandom_range(0, 2) == 0) ? 24'h000000 : 24'($urandom());
			set_scan($urandom_range(0, 3) == 0, $urandom_range(0, 3) == 0, 1'($urandom_range(0, 1)), av);
			run(1'b0, 16'($urandom_range(0, 40)));
		end
		final_report();
	end
endmodule // scan_data_status_responder_test
